/* File: rtl/imc_pkg.sv */
// imc_pkg: register map, field positions, codes and reset values
package imc_pkg;
	// bus widths
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	// byte offsets on the register bus
	localparam logic [4:0] OFF_CTL1  = 5'h00;
	localparam logic [4:0] OFF_CTL2  = 5'h04;
	localparam logic [4:0] OFF_DATA  = 5'h08;
	localparam logic [4:0] OFF_BAUD  = 5'h0C;
	localparam logic [4:0] OFF_ISTAT = 5'h10;
	localparam logic [4:0] OFF_IMASK = 5'h14;
	localparam logic [4:0] OFF_FWPIN = 5'h18;
	// control one fields
	localparam int B_WCOL = 7;
	localparam int B_OVF  = 6;
	localparam int B_EN   = 5;
	// control two fields
	localparam int B_GENERAL_CALL_ENABLE  = 7;
	localparam int B_ACKST = 6;
	localparam int B_ACK_DATA_BIT = 5;
	localparam int B_ACK_SEQUENCE_ENABLE = 4;
	localparam int B_MASTER_RECEIVE_ENABLE  = 3;
	localparam int B_PEN   = 2;
	localparam int B_REPEATED_START_ENABLE  = 1;
	localparam int B_SEN   = 0;
	// interrupt status bits
	localparam int N_IRQ   = 4;
	localparam int I_DONE  = 0;
	localparam int I_START = 1;
	localparam int I_STOP  = 2;
	localparam int I_GCALL = 3;
	// mode codes
	localparam logic [3:0] MODE_S7   = 4'h6;
	localparam logic [3:0] MODE_S10  = 4'h7;
	localparam logic [3:0] MODE_M    = 4'h8;
	localparam logic [3:0] MODE_FW   = 4'hB;
	localparam logic [3:0] MODE_S7I  = 4'hE;
	localparam logic [3:0] MODE_S10I = 4'hF;
	// reset values
	localparam logic [7:0] CTL1_RST  = 8'h00;
	localparam logic [7:0] CTL2_RST  = 8'h00;
	localparam logic [7:0] BAUD_RST  = 8'h09;
	localparam logic [1:0] FWPIN_RST = 2'h3;
	localparam logic [3:0] IRQ_RST   = 4'h0;
	// last quarter of a bit, last bit indices
	localparam logic [1:0] PH_LAST  = 2'h3;
	localparam logic [1:0] PH_SAMP  = 2'h2;
	localparam logic [3:0] BIT_ACK  = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	// master sequencer states
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_START = 6'h02,
		ST_STOP  = 6'h04,
		ST_TX    = 6'h08,
		ST_RX    = 6'h10,
		ST_ACK   = 6'h20
	} imc_state_t;
endpackage : imc_pkg

/* File: rtl/imc_top.sv */
// imc_top: two-wire port mode decode, master sequencer, register slave
`timescale 1ns/100ps
module imc_top (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// avalon-mm slave
	input  wire logic [imc_pkg::ADDR_W-1:0] address,
	input  wire logic                       read,
	input  wire logic                       write,
	input  wire logic [3:0]                 byteenable,
	input  wire logic [imc_pkg::DATA_W-1:0] writedata,
	output logic      [imc_pkg::DATA_W-1:0] readdata,
	output logic                            waitrequest,
	// interrupt
	output logic                            irq,
	// bus pins, open drain
	input  wire logic                       sdaIn,
	output logic                            sdaOut,
	output logic                            sdaOe,
	input  wire logic                       sclIn,
	output logic                            sclOut,
	output logic                            sclOe,
	output logic                            portOwnsPins
);
	import imc_pkg::*;

	// slave decode: 7-bit and 10-bit codes, with or without irqs
	function automatic logic isSlave(input logic [3:0] m);
		isSlave = (m == MODE_S7) || (m == MODE_S10) ||
			(m == MODE_S7I) || (m == MODE_S10I);
	endfunction : isSlave

	// pin synchronisers and edge history
	logic [1:0]  sdaSync_ff;        // [0] feeds [1] only
	logic [1:0]  sclSync_ff;
	logic        sdaOld_ff;         // delayed synced level
	logic        sclOld_ff;
	logic [1:0]  nxt_sdaSync;
	logic [1:0]  nxt_sclSync;

	// registers and sequencer state
	logic [7:0]  ctl1_ff;           // wcol, ovf, en, ckp, mode
	logic [7:0]  ctl2_ff;           // general_call_enable .. sen
	logic [7:0]  dataBuf_ff;        // serial data buffer
	logic        bufFull_ff;        // buffer holds unread byte
	logic [7:0]  baud_ff;           // baud reload value
	logic [N_IRQ-1:0] stat_ff;      // sticky interrupt status
	logic [N_IRQ-1:0] mask_ff;      // interrupt mask
	logic [1:0]  fwPins_ff;         // firmware pin release
	imc_state_t  state_ff;
	logic [1:0]  phase_ff;          // quarter of current bit
	logic [7:0]  qCnt_ff;           // clocks within quarter
	logic [3:0]  bitCnt_ff;
	logic [7:0]  shift_ff;          // master shift register
	logic [7:0]  slvShift_ff;       // slave shift register
	logic [3:0]  slvCnt_ff;
	logic        slvFirst_ff;       // next byte is address
	logic        ack_ff;            // bus answer cycle
	logic [7:0]  rdData_ff;
	logic        sdaOe_ff;
	logic        sclOe_ff;
	logic        hold_ff;           // clock held low between sequences
	// next values
	logic [7:0]  nxt_ctl1, nxt_ctl2, nxt_dataBuf, nxt_baud;
	logic        nxt_bufFull, nxt_ack, nxt_slvFirst;
	logic [N_IRQ-1:0] nxt_stat, nxt_mask, ev;
	logic [1:0]  nxt_fwPins, nxt_phase;
	imc_state_t  nxt_state;
	logic [7:0]  nxt_qCnt, nxt_shift, nxt_slvShift, nxt_rdData;
	logic [3:0]  nxt_bitCnt, nxt_slvCnt;
	logic        nxt_sdaOe, nxt_sclOe;
	logic        nxt_hold;
	// helpers
	logic        wrEn, tick, mOn, idle, sdaLow, sclLow;
	logic        sda, scl, sdaRise, sdaFall, sclRise;
	logic [4:0]  setReq;
	logic [7:0]  rdMux;

	// bus handshake: one wait cycle, answer on the second edge
	assign waitrequest  = (read | write) & ~ack_ff;
	assign readdata     = {24'h000000, rdData_ff};
	assign irq          = |(stat_ff & mask_ff);
	assign sdaOut       = 1'b0;
	assign sclOut       = 1'b0;
	assign sdaOe        = sdaOe_ff;
	assign sclOe        = sclOe_ff;
	assign portOwnsPins = ctl1_ff[B_EN];

	// synced levels and edges
	assign sda     = sdaSync_ff[1];
	assign scl     = sclSync_ff[1];
	assign sdaRise = sda & ~sdaOld_ff;
	assign sdaFall = ~sda & sdaOld_ff;
	assign sclRise = scl & ~sclOld_ff;

	// synchroniser next values
	always_comb begin
		nxt_sdaSync = {sdaSync_ff[0], sdaIn};
		nxt_sclSync = {sclSync_ff[0], sclIn};
	end

	// synchroniser registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sdaSync_ff <= 2'h3;
			sclSync_ff <= 2'h3;
			sdaOld_ff  <= 1'b1;
			sclOld_ff  <= 1'b1;
		end else begin
			sdaSync_ff <= nxt_sdaSync;
			sclSync_ff <= nxt_sclSync;
			sdaOld_ff  <= sda;
			sclOld_ff  <= scl;
		end
	end

	// register read multiplexer
	always_comb begin
		case (address)
			OFF_CTL1:  rdMux = ctl1_ff;
			OFF_CTL2:  rdMux = ctl2_ff;
			OFF_DATA:  rdMux = dataBuf_ff;
			OFF_BAUD:  rdMux = baud_ff;
			OFF_ISTAT: rdMux = {4'h0, stat_ff};
			OFF_IMASK: rdMux = {4'h0, mask_ff};
			OFF_FWPIN: rdMux = {4'h0, scl, sda, fwPins_ff};
			default:   rdMux = 8'h00;  // unmapped reads zero
		endcase
	end

	// pin drive per sequencer state and quarter
	always_comb begin
		case (state_ff)
			ST_START: begin
				// held clock: release data first, then clock
				sclLow = (phase_ff == PH_LAST) |
					((phase_ff == 2'h0) & hold_ff);
				sdaLow = phase_ff[1];
			end
			ST_STOP: begin
				sclLow = (phase_ff == 2'h0);
				sdaLow = (phase_ff != PH_LAST);
			end
			ST_TX: begin
				sclLow = ~^phase_ff;
				sdaLow = (bitCnt_ff != BIT_ACK) & ~shift_ff[7];
			end
			ST_RX: begin
				sclLow = ~^phase_ff;
				sdaLow = 1'b0;
			end
			ST_ACK: begin
				sclLow = ~^phase_ff;
				sdaLow = ~ctl2_ff[B_ACK_DATA_BIT];
			end
			default: begin
				// idle keeps the clock low inside a transfer
				sclLow = hold_ff;
				sdaLow = 1'b0;
			end
		endcase
	end

	// bus slave, registers, master sequencer and slave monitor
	always_comb begin
		nxt_ctl1     = ctl1_ff;
		nxt_ctl2     = ctl2_ff;
		nxt_dataBuf  = dataBuf_ff;
		nxt_bufFull  = bufFull_ff;
		nxt_baud     = baud_ff;
		nxt_mask     = mask_ff;
		nxt_fwPins   = fwPins_ff;
		nxt_state    = state_ff;
		nxt_phase    = phase_ff;
		nxt_qCnt     = qCnt_ff;
		nxt_bitCnt   = bitCnt_ff;
		nxt_shift    = shift_ff;
		nxt_slvShift = slvShift_ff;
		nxt_slvCnt   = slvCnt_ff;
		nxt_slvFirst = slvFirst_ff;
		nxt_rdData   = rdData_ff;
		nxt_hold     = hold_ff;
		ev           = '0;
		nxt_ack      = (read | write) & ~ack_ff;
		wrEn         = write & ack_ff & byteenable[0];
		mOn          = ctl1_ff[B_EN] & (ctl1_ff[3:0] == MODE_M);
		idle         = (state_ff == ST_IDLE) & (ctl2_ff[4:0] == 5'h00);
		// quarter lasts reload plus one clocks
		tick         = (qCnt_ff == baud_ff);
		setReq       = writedata[4:0] & (~writedata[4:0] + 5'h01);
		// read data captured in the wait cycle, buffer drains
		if ((read & ~ack_ff)) begin
			nxt_rdData = rdMux;
		end
		if (read & ack_ff & (address == OFF_DATA)) begin
			nxt_bufFull = 1'b0;
		end
		// software writes
		if (wrEn) begin
			case (address)
				OFF_CTL1: begin
					// flags clear on zero, cannot be set
					nxt_ctl1 = {writedata[7:6] & ctl1_ff[7:6],
						writedata[5:0]};
				end
				OFF_CTL2: begin
					nxt_ctl2[B_GENERAL_CALL_ENABLE]  = writedata[B_GENERAL_CALL_ENABLE];
					nxt_ctl2[B_ACK_DATA_BIT] = writedata[B_ACK_DATA_BIT];
					if (idle && mOn) begin
						nxt_ctl2[4:0] = setReq;
					end
				end
				OFF_DATA: begin
					if (mOn) begin
						if (idle) begin
							nxt_shift  = writedata[7:0];
							nxt_state  = ST_TX;
							nxt_bitCnt = 4'h0;
						end else begin
							nxt_ctl1[B_WCOL] = 1'b1;
						end
					end else begin
						nxt_dataBuf = writedata[7:0];
					end
				end
				OFF_BAUD:  nxt_baud   = writedata[7:0];
				OFF_IMASK: nxt_mask   = writedata[N_IRQ-1:0];
				OFF_FWPIN: nxt_fwPins = writedata[1:0];
				default: ;  // unmapped writes ignored
			endcase
		end
		// launch a sequence from an accepted enable
		if (state_ff == ST_IDLE && mOn && nxt_state == ST_IDLE) begin
			if (ctl2_ff[B_SEN] | ctl2_ff[B_REPEATED_START_ENABLE]) begin
				nxt_state = ST_START;
			end else if (ctl2_ff[B_PEN]) begin
				nxt_state = ST_STOP;
			end else if (ctl2_ff[B_ACK_SEQUENCE_ENABLE]) begin
				nxt_state = ST_ACK;
			end else if (ctl2_ff[B_MASTER_RECEIVE_ENABLE]) begin
				nxt_state = ST_RX;
				nxt_bitCnt = 4'h0;
			end
		end
		// quarter timing and bit progress
		if (!mOn) begin
			nxt_state     = ST_IDLE;
			nxt_ctl2[4:0] = 5'h00;
			nxt_phase     = 2'h0;
			nxt_qCnt      = 8'h00;
			nxt_hold      = 1'b0;
		end else if (state_ff == ST_IDLE) begin
			nxt_phase = 2'h0;
			nxt_qCnt  = 8'h00;
		end else if (!tick) begin
			nxt_qCnt = qCnt_ff + 8'h01;
		end else begin
			nxt_qCnt  = 8'h00;
			nxt_phase = phase_ff + 2'h1;
			if (phase_ff == PH_SAMP) begin
				if (state_ff == ST_TX && bitCnt_ff == BIT_ACK) begin
					nxt_ctl2[B_ACKST] = sda;
				end else if (state_ff == ST_RX) begin
					nxt_shift = {shift_ff[6:0], sda};
				end
			end else if (phase_ff == PH_LAST) begin
				// bus stays held after all but a stop
				nxt_hold = (state_ff != ST_STOP);
				case (state_ff)
					ST_START, ST_STOP, ST_ACK: begin
						nxt_ctl2[4:0] = 5'h00;
						nxt_state     = ST_IDLE;
						ev[I_DONE]    = 1'b1;
					end
					ST_TX: begin
						nxt_shift  = {shift_ff[6:0], 1'b1};
						nxt_bitCnt = bitCnt_ff + 4'h1;
						if (bitCnt_ff == BIT_ACK) begin
							nxt_state  = ST_IDLE;
							ev[I_DONE] = 1'b1;
						end
					end
					ST_RX: begin
						nxt_bitCnt = bitCnt_ff + 4'h1;
						if (bitCnt_ff == BIT_LAST) begin
							// no overflow set in master mode
							nxt_ctl2[B_MASTER_RECEIVE_ENABLE] = 1'b0;
							nxt_dataBuf      = shift_ff;
							nxt_bufFull      = 1'b1;
							nxt_state        = ST_IDLE;
							ev[I_DONE]       = 1'b1;
						end
					end
					default: nxt_state = ST_IDLE;
				endcase
			end
		end
		// slave monitor, idle outside slave codes
		if (ctl1_ff[B_EN] && isSlave(ctl1_ff[3:0])) begin
			if (scl && sdaFall) begin
				ev[I_START]  = ctl1_ff[3];
				nxt_slvCnt   = 4'h0;
				nxt_slvFirst = 1'b1;
			end else if (scl && sdaRise) begin
				ev[I_STOP]   = ctl1_ff[3];
				nxt_slvFirst = 1'b0;
			end else if (sclRise) begin
				nxt_slvCnt = slvCnt_ff + 4'h1;
				if (slvCnt_ff == BIT_ACK) begin
					nxt_slvCnt = 4'h0;
				end else begin
					nxt_slvShift = {slvShift_ff[6:0], sda};
				end
				if (slvCnt_ff == BIT_LAST) begin
					nxt_dataBuf  = {slvShift_ff[6:0], sda};
					nxt_bufFull  = 1'b1;
					nxt_slvFirst = 1'b0;
					nxt_ctl1[B_OVF] = bufFull_ff | nxt_ctl1[B_OVF];
					ev[I_GCALL] = slvFirst_ff & ctl2_ff[B_GENERAL_CALL_ENABLE] &
						({slvShift_ff[6:0], sda} == 8'h00);
				end
			end
		end
		// sticky status: write one clears, a new event wins
		nxt_stat = stat_ff;
		if (wrEn && address == OFF_ISTAT) begin
			nxt_stat = stat_ff & ~writedata[N_IRQ-1:0];
		end
		nxt_stat = nxt_stat | ev;
		// open-drain drive, released while port disabled
		if (!ctl1_ff[B_EN]) begin
			nxt_sdaOe = 1'b0;
			nxt_sclOe = 1'b0;
		end else if (ctl1_ff[3:0] == MODE_FW) begin
			nxt_sdaOe = ~fwPins_ff[0];
			nxt_sclOe = ~fwPins_ff[1];
		end else begin
			nxt_sdaOe = sdaLow;
			nxt_sclOe = sclLow;
		end
	end

	// main registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl1_ff     <= CTL1_RST;
			ctl2_ff     <= CTL2_RST;
			dataBuf_ff  <= 8'h00;
			bufFull_ff  <= 1'b0;
			baud_ff     <= BAUD_RST;
			stat_ff     <= IRQ_RST;
			mask_ff     <= IRQ_RST;
			fwPins_ff   <= FWPIN_RST;
			state_ff    <= ST_IDLE;
			phase_ff    <= 2'h0;
			qCnt_ff     <= 8'h00;
			bitCnt_ff   <= 4'h0;
			shift_ff    <= 8'h00;
			slvShift_ff <= 8'h00;
			slvCnt_ff   <= 4'h0;
			slvFirst_ff <= 1'b0;
			ack_ff      <= 1'b0;
			rdData_ff   <= 8'h00;
			sdaOe_ff    <= 1'b0;
			sclOe_ff    <= 1'b0;
			hold_ff     <= 1'b0;
		end else begin
			ctl1_ff     <= nxt_ctl1;
			ctl2_ff     <= nxt_ctl2;
			dataBuf_ff  <= nxt_dataBuf;
			bufFull_ff  <= nxt_bufFull;
			baud_ff     <= nxt_baud;
			stat_ff     <= nxt_stat;
			mask_ff     <= nxt_mask;
			fwPins_ff   <= nxt_fwPins;
			state_ff    <= nxt_state;
			phase_ff    <= nxt_phase;
			qCnt_ff     <= nxt_qCnt;
			bitCnt_ff   <= nxt_bitCnt;
			shift_ff    <= nxt_shift;
			slvShift_ff <= nxt_slvShift;
			slvCnt_ff   <= nxt_slvCnt;
			slvFirst_ff <= nxt_slvFirst;
			ack_ff      <= nxt_ack;
			rdData_ff   <= nxt_rdData;
			sdaOe_ff    <= nxt_sdaOe;
			sclOe_ff    <= nxt_sclOe;
			hold_ff     <= nxt_hold;
		end
	end

	// sequencer runs only after a cycle in master code
	mode_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff != ST_IDLE) |-> ($past(ctl1_ff[3:0]) == MODE_M))
		else $error("sequencer active outside master mode");
	// start interrupt only from the interrupting slave codes
	start_irq_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(stat_ff[I_START]) |->
		($past(ctl1_ff[3]) && isSlave($past(ctl1_ff[3:0]))))
		else $error("start interrupt outside slave irq mode");
	// quarter advances only at the reload count
	quarter_len_a: assert property (@(posedge clk) disable iff (!resetn)
		($past(state_ff) != ST_IDLE && $past(mOn) && $changed(phase_ff)) |->
		($past(qCnt_ff) == $past(baud_ff)))
		else $error("quarter ended at wrong count");
	// firmware mode clock drive follows pin register bit 1
	fw_pins_a: assert property (@(posedge clk) disable iff (!resetn)
		(ctl1_ff[B_EN] && ctl1_ff[3:0] == MODE_FW) |=>
		(sclOe_ff == !$past(fwPins_ff[1])))
		else $error("firmware clock drive mismatch");
	// overflow never rises while in master code
	no_ovf_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(ctl1_ff[B_OVF]) |-> ($past(ctl1_ff[3:0]) != MODE_M))
		else $error("overflow set in master mode");
	// general call flag needs the enable
	gen_call_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(stat_ff[I_GCALL]) |-> $past(ctl2_ff[B_GENERAL_CALL_ENABLE]))
		else $error("general call without enable");
	// ack enable clears at the end of its bit
	ack_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_ACK && phase_ff == PH_LAST && tick) |=>
		(!ctl2_ff[B_ACK_SEQUENCE_ENABLE] && state_ff == ST_IDLE))
		else $error("ack enable not cleared");
	// ack bit on the data pin mid-bit
	ack_drive_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_ACK && phase_ff == PH_SAMP &&
		$past(state_ff) == ST_ACK) |-> (sdaOe_ff == !ctl2_ff[B_ACK_DATA_BIT]))
		else $error("ack bit not driven");
	// receive enable clears with the byte in the buffer
	rx_done_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_RX && bitCnt_ff == BIT_LAST &&
		phase_ff == PH_LAST && tick) |=> (!ctl2_ff[B_MASTER_RECEIVE_ENABLE] && bufFull_ff))
		else $error("receive enable not cleared");
	// no enable newly set while busy
	no_queue_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff != ST_IDLE) |=>
		((ctl2_ff[4:0] & ~$past(ctl2_ff[4:0])) == 5'h00))
		else $error("enable queued while busy");
	// pins released one cycle after disable
	pin_release_a: assert property (@(posedge clk) disable iff (!resetn)
		!ctl1_ff[B_EN] |=> (!sdaOe_ff && !sclOe_ff))
		else $error("pins driven while disabled");
endmodule : imc_top

/* File: tb/imc_bus_partner.sv */
// imc_bus_partner: pulled-up two-wire bus with a behavioural far-side device
`timescale 1ns/100ps
module imc_bus_partner (
	// open-drain pulls from the port
	input  wire logic        dutSdaOe,
	input  wire logic        dutSclOe,
	// far-side behaviour selects
	input  wire logic        ackOn,
	input  wire logic        rdMode,
	input  wire logic [7:0]  txByte,
	// resolved bus levels
	output logic             sdaLine,
	output logic             sclLine,
	// observations of the port's traffic
	output logic [7:0]       rxByte,
	output logic             ackSeen,
	output logic [31:0]      sclPeriod
);
	logic sSdaLow;  // far-side slave pull on data
	logic mSdaLow;  // far-side master pull on data
	logic mSclLow;  // far-side master pull on clock
	int   bitCnt;   // clock rises since start
	time  lastRise; // previous clock rise
	initial begin
		{sSdaLow, mSdaLow, mSclLow, ackSeen} = 4'h0;
		rxByte = 8'h00;
		sclPeriod = 32'h0;
		bitCnt = 0;
		lastRise = 0;
	end
	assign sdaLine = !(dutSdaOe || sSdaLow || mSdaLow);
	assign sclLine = !(dutSclOe || mSclLow);
	// start or stop restarts the bit count
	always @(sdaLine) begin
		if (sclLine) bitCnt = 0;
	end
	// shift data, note ack slot and clock period
	always @(posedge sclLine) begin
		if (bitCnt < 8) rxByte = {rxByte[6:0], sdaLine};
		else ackSeen = sdaLine;
		sclPeriod = 32'($time - lastRise);
		lastRise = $time;
		bitCnt = (bitCnt + 1) % 9;
	end
	// present read bits or ack only while clock is low
	always @(negedge sclLine or rdMode or txByte) begin
		if (rdMode) sSdaLow = (bitCnt < 8) && !txByte[7 - bitCnt];
		else sSdaLow = ackOn && (bitCnt == 8);
	end
	// acting as a bus master: start, one byte, ack slot, stop
	task sendFrame(input logic [7:0] b);
		mSdaLow = 1'b1;
		#200 mSclLow = 1'b1;
		for (int i = 0; i < 9; i++) begin
			#200 mSdaLow = (i < 8) ? !b[7 - i] : 1'b0;
			#200 mSclLow = 1'b0;
			#200 mSclLow = 1'b1;
		end
		#200 mSdaLow = 1'b1;
		#200 mSclLow = 1'b0;
		#200 mSdaLow = 1'b0;
		#400;
	endtask : sendFrame
endmodule : imc_bus_partner

/* File: tb/test_i2c_mode_and_master_sequence_control.sv */
// test_i2c_mode_and_master_sequence_control: register-level bench
`timescale 1ns/100ps
module test_i2c_mode_and_master_sequence_control;
	import imc_pkg::*;
	logic              clk, resetn, read, write, irq, waitrequest;
	logic              sdaIn, sclIn, sdaOe, sclOe, portOwnsPins;
	logic              sdaOut, sclOut;
	logic              waitSeen, ackOn, rdMode, ackSeen;
	logic [ADDR_W-1:0] address;
	logic [3:0]        byteenable;
	logic [DATA_W-1:0] writedata, readdata, rdSeen;
	logic [7:0]        txByte, rxByte;
	logic [31:0]       sclPeriod;
	int                num_errors, checked, cyc;
	// reset table and slave mode table
	logic [4:0] offs [6] = '{OFF_CTL1, OFF_CTL2, OFF_BAUD, OFF_ISTAT,
		OFF_IMASK, 5'h1C};
	logic [7:0] rsts [6] = '{8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00};
	logic [7:0] sMode [4] = '{8'h26, 8'h27, 8'h2E, 8'h2F};
	logic [7:0] sGc [4] = '{8'h80, 8'h00, 8'h00, 8'h80};
	logic [7:0] sExp [4] = '{8'h08, 8'h00, 8'h06, 8'h0E};
	imc_top imc_top_inst (.clk(clk), .resetn(resetn), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn),
		.sclOut(sclOut), .sclOe(sclOe),
		.portOwnsPins(portOwnsPins));
	imc_bus_partner imc_bus_partner_inst (.dutSdaOe(sdaOe),
		.dutSclOe(sclOe), .ackOn(ackOn), .rdMode(rdMode), .txByte(txByte),
		.sdaLine(sdaIn), .sclLine(sclIn), .rxByte(rxByte),
		.ackSeen(ackSeen), .sclPeriod(sclPeriod));
	// clock and cycle ceiling
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results;
		end
	end
	// bus answer as it stands before the next rising edge
	always @(negedge clk) begin
		waitSeen = waitrequest;
		rdSeen = readdata;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= a;
		writedata <= {24'h000000, d};
		write <= 1'b1;
		do @(posedge clk); while (waitSeen !== 1'b0);
		write <= 1'b0;
	endtask : wr
	task rdc(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitSeen !== 1'b0);
		read <= 1'b0;
		chk(rdSeen, {24'h000000, e});
	endtask : rdc
	// clear done flag, issue a write to the given register, wait for done
	task seq(input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wr(OFF_ISTAT, 8'h01);
		wr(a, d);
		while (irq !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n == 3000) begin
			num_errors++;
			$display("Error %0t: sequence never finished", $time);
			results;
		end
	endtask : seq
	task results;
		if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	initial begin
		{clk, resetn, read, write, ackOn, rdMode} = 6'h00;
		address = 5'h00;
		byteenable = 4'hF;
		writedata = 32'h0;
		txByte = 8'h00;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) rdc(offs[i], rsts[i]);
		chk(portOwnsPins, 1'b0);
		chk({sdaOut, sclOut}, 2'b00);
		rdc(OFF_FWPIN, 8'h0F);
		wr(OFF_BAUD, 8'h03);
		wr(OFF_IMASK, 8'h01);
		for (int m = 0; m < 16; m++) begin
			wr(OFF_CTL1, 8'h20 | 8'(m));
			rdc(OFF_CTL1, 8'h20 | 8'(m));
			wr(OFF_CTL2, 8'h01);
			repeat (40) @(negedge clk);
			chk(irq, 32'(m == 8));
			wr(OFF_ISTAT, 8'h0F);
		end
		wr(OFF_CTL1, 8'h2B);
		wr(OFF_FWPIN, 8'h00);
		repeat (2) @(negedge clk);
		chk({sdaOe, sclOe, portOwnsPins}, 3'b111);
		wr(OFF_FWPIN, 8'h03);
		repeat (2) @(negedge clk);
		chk({sdaOe, sclOe}, 2'b00);
		wr(OFF_CTL1, 8'h0B);
		repeat (2) @(negedge clk);
		chk(portOwnsPins, 1'b0);
		// master transmit, busy port refuses more work
		wr(OFF_CTL1, 8'h28);
		seq(OFF_CTL2, 8'h01);
		ackOn = 1'b1;
		wr(OFF_ISTAT, 8'h01);
		wr(OFF_DATA, 8'hA5);
		wr(OFF_DATA, 8'h5A);
		wr(OFF_CTL2, 8'h01);
		rdc(OFF_CTL2, 8'h00);
		rdc(OFF_CTL1, 8'hA8);
		seq(OFF_ISTAT, 8'h00);
		chk(rxByte, 8'hA5);
		chk(sclPeriod, 32'd320);
		rdc(OFF_CTL2, 8'h00);
		wr(OFF_CTL1, 8'h28);
		ackOn = 1'b0;
		seq(OFF_DATA, 8'hC3);
		chk(rxByte, 8'hC3);
		rdc(OFF_CTL2, 8'h40);
		// repeated start leaves data released, clock held
		seq(OFF_CTL2, 8'h02);
		repeat (2) @(negedge clk);
		chk({sdaIn, sclIn}, 2'b10);
		// master receive twice with both ack values
		txByte = 8'h3C;
		rdMode = 1'b1;
		seq(OFF_CTL2, 8'h08);
		rdc(OFF_CTL2, 8'h40);
		seq(OFF_CTL2, 8'h30);
		chk(ackSeen, 1'b1);
		txByte = 8'h96;
		seq(OFF_CTL2, 8'h08);
		seq(OFF_CTL2, 8'h10);
		chk(ackSeen, 1'b0);
		rdc(OFF_CTL2, 8'h40);
		rdc(OFF_CTL1, 8'h28);
		rdc(OFF_DATA, 8'h96);
		rdMode = 1'b0;
		// stop hands both lines back to the pull-ups
		seq(OFF_CTL2, 8'h04);
		repeat (2) @(negedge clk);
		chk({sdaIn, sclIn}, 2'b11);
		rdc(OFF_CTL2, 8'h40);
		// slave modes watching a general call frame
		wr(OFF_IMASK, 8'h0F);
		for (int k = 0; k < 4; k++) begin
			wr(OFF_CTL1, sMode[k]);
			wr(OFF_CTL2, sGc[k]);
			wr(OFF_ISTAT, 8'h0F);
			imc_bus_partner_inst.sendFrame(8'h00);
			rdc(OFF_ISTAT, sExp[k]);
			@(negedge clk);
			chk(irq, 32'(sExp[k] != 8'h00));
			chk({sdaOe, sclOe}, 2'b00);
		end
		results;
	end
endmodule : test_i2c_mode_and_master_sequence_control
